// ---- hw/hex_ascii_convert_bit_shift.sv ----
/*
  Datapath for the hex/text conversion, bit test and single-bit shift group.
  Assumes the sequencer issues one command per scan with start_i, holds off
  until done_o, and serves table reads one cycle after rd_en_o is sampled.
*/
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// RQ1: Hex-to-text converts n words, output on
// RQ2: Hex-to-text count lies in 1 to 32
// RQ3: Top source nibble lands in low byte
// RQ4: Nibbles map to 0x30-0x39, 0x41-0x46; 2n words
// RQ5: Indexed source with count above 1 errors
// RQ6: Low source byte becomes top destination nibble
// RQ7: Only 0x30-0x39, 0x41-0x46 accepted as characters
// RQ8: Text-to-hex count lies in 1 to 64
// RQ9: Bad character: no write, output off, error
// RQ10: Indexed text-to-hex source permits count 1 only
// RQ11: Odd count leaves last low nibbles undefined
// RQ12: Bit test output is nonzero AND result
// RQ13: Right shift fills zero, carry takes LSB
// RQ14: Right shift output is new LSB
// RQ15: Left shift fills zero, carry takes MSB
// RQ16: Left shift output is new MSB
// RQ17: Condition off: nothing changes, output off
// RQ18: All words are 16 bits wide
// RQ19: Executes on every scan with condition on
module hex_ascii_convert_bit_shift #(
  parameter logic [6:0] H2T_MAX = hex_ascii_pkg::H2T_MAX_COUNT,
  parameter logic [6:0] T2H_MAX = hex_ascii_pkg::T2H_MAX_COUNT
) (
  // Clock and reset
  input  wire logic                 clk_sys_i,
  input  wire logic                 nrst_i,
  // Command from the sequencer
  input  wire logic                 start_i,
  input  wire hex_ascii_pkg::cmd_t  cmd_i,
  input  wire logic                 err_clr_i,
  // Table memory
  output logic                      rd_en_o,
  output logic [5:0]                rd_addr_o,
  input  wire logic [15:0]          mem_rdata_i,
  output logic                      wr_en_o,
  output logic [5:0]                wr_addr_o,
  output logic [15:0]               wr_data_o,
  // Results
  output logic                      busy_o,
  output logic                      done_o,
  output logic                      out_bit_o,
  output logic                      boundary_err_o,
  output logic                      carry_flag_o,
  output logic                      error_flag_o,
  output hex_ascii_pkg::word_t      result_word_o
);

  if (H2T_MAX < 7'h01 || H2T_MAX > 7'h20 || T2H_MAX < 7'h01 || T2H_MAX > 7'h40) begin : g_chk
    $error("count limits outside what the address width serves");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Character helpers

  function automatic logic [7:0] to_ascii(input logic [3:0] nib);
    logic [7:0] wide;
    wide = {4'h0, nib};
    if (nib < 4'ha) begin
      to_ascii = hex_ascii_pkg::DIGIT_BASE + wide;              // see RQ4
    end else begin
      to_ascii = hex_ascii_pkg::LETTER_BASE + wide - hex_ascii_pkg::LETTER_OFS;
    end
  endfunction : to_ascii

  // Returns {legal, nibble}
  function automatic logic [4:0] from_ascii(input logic [7:0] ch);
    logic [7:0] d;
    d = 8'h00;
    if (ch >= hex_ascii_pkg::DIGIT_BASE && ch <= hex_ascii_pkg::DIGIT_LAST) begin
      d = ch - hex_ascii_pkg::DIGIT_BASE;                       // see RQ7
      from_ascii = {1'b1, d[3:0]};
    end else if (ch >= hex_ascii_pkg::LETTER_BASE && ch <= hex_ascii_pkg::LETTER_LAST) begin
      d = ch - hex_ascii_pkg::LETTER_BASE + hex_ascii_pkg::LETTER_OFS;
      from_ascii = {1'b1, d[3:0]};
    end else begin
      from_ascii = 5'h00;
    end
  endfunction : from_ascii

  ////////////////////////////////////////////////////////////////////////////
  // Decode of the incoming command

  typedef enum logic [2:0] {ST_IDLE, ST_ISSUE, ST_WAIT, ST_CAPT, ST_W1} state_t;

  state_t              state_q;
  hex_ascii_pkg::op_t  op_q;
  logic [6:0]          count_q;
  logic [6:0]          idx_q;
  logic                pass_q;
  logic [7:0]          hi_q;

  logic is_conv;
  logic bad_count;
  logic launch;
  logic take;
  logic [4:0] dec_lo;
  logic [4:0] dec_hi;
  logic last;
  logic fin_ok;
  logic fin_err;

  assign take    = (state_q == ST_IDLE) && start_i;             // see RQ19
  assign is_conv = (cmd_i.op == hex_ascii_pkg::hex_to_text_op) ||
                   (cmd_i.op == hex_ascii_pkg::text_to_hex_op);
  // Out-of-range counts are refused like an indexed overrun
  assign bad_count = is_conv && ((cmd_i.count == 7'h00) ||
                     (cmd_i.src_indexed && cmd_i.count != hex_ascii_pkg::INDEXED_COUNT) ||  // see RQ5 RQ10
                     (cmd_i.op == hex_ascii_pkg::hex_to_text_op && cmd_i.count > H2T_MAX) ||  // see RQ2
                     (cmd_i.op == hex_ascii_pkg::text_to_hex_op && cmd_i.count > T2H_MAX));   // see RQ8
  assign launch  = take && cmd_i.cond && is_conv && !bad_count;
  assign dec_lo  = from_ascii(mem_rdata_i[7:0]);
  assign dec_hi  = from_ascii(mem_rdata_i[15:8]);
  assign last    = (idx_q == count_q - 7'h01);

  // Completion of a table conversion
  always_comb begin
    fin_ok  = 1'b0;
    fin_err = 1'b0;
    if (state_q == ST_W1) begin
      fin_ok = last;
    end else if (state_q == ST_CAPT && op_q == hex_ascii_pkg::text_to_hex_op) begin
      if (!pass_q) begin
        fin_err = !(dec_lo[4] && dec_hi[4]);                    // see RQ9
      end else begin
        fin_ok = last;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing: validation pass first so a bad table writes nothing

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= ST_IDLE;
      op_q    <= hex_ascii_pkg::hex_to_text_op;
      count_q <= 7'h00;
      idx_q   <= 7'h00;
      pass_q  <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (launch) begin
            op_q    <= cmd_i.op;
            count_q <= cmd_i.count;
            idx_q   <= 7'h00;
            pass_q  <= (cmd_i.op == hex_ascii_pkg::hex_to_text_op);
            state_q <= ST_ISSUE;                                // see RQ1
          end
        end
        ST_ISSUE: state_q <= ST_WAIT;
        ST_WAIT:  state_q <= ST_CAPT;
        ST_CAPT: begin
          if (op_q == hex_ascii_pkg::hex_to_text_op) begin
            state_q <= ST_W1;
          end else if (fin_err || fin_ok) begin
            state_q <= ST_IDLE;
          end else if (!pass_q && last) begin
            pass_q  <= 1'b1;
            idx_q   <= 7'h00;
            state_q <= ST_ISSUE;
          end else begin
            idx_q   <= idx_q + 7'h01;
            state_q <= ST_ISSUE;
          end
        end
        ST_W1: begin
          if (last) begin
            state_q <= ST_IDLE;
          end else begin
            idx_q   <= idx_q + 7'h01;
            state_q <= ST_ISSUE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Table reads and writes

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_en_o   <= 1'b0;
      rd_addr_o <= 6'h00;
    end else begin
      rd_en_o   <= (state_q == ST_ISSUE);
      rd_addr_o <= idx_q[5:0];
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_en_o   <= 1'b0;
      wr_addr_o <= 6'h00;
      wr_data_o <= hex_ascii_pkg::WORD_RESET;
      hi_q      <= 8'h00;
    end else begin
      wr_en_o <= 1'b0;
      if (state_q == ST_CAPT && op_q == hex_ascii_pkg::hex_to_text_op) begin
        // Top nibble goes to the low byte of the first word
        wr_en_o   <= 1'b1;
        wr_addr_o <= {idx_q[4:0], 1'b0};
        wr_data_o <= {to_ascii(mem_rdata_i[11:8]), to_ascii(mem_rdata_i[15:12])};  // see RQ3
        hi_q      <= mem_rdata_i[7:0];
      end else if (state_q == ST_W1) begin
        wr_en_o   <= 1'b1;
        wr_addr_o <= {idx_q[4:0], 1'b1};                        // see RQ4
        wr_data_o <= {to_ascii(hi_q[3:0]), to_ascii(hi_q[7:4])};
      end else if (state_q == ST_CAPT && pass_q) begin
        // Low byte of each source word is the more significant nibble
        if (!idx_q[0]) begin
          hi_q <= {dec_lo[3:0], dec_hi[3:0]};                   // see RQ6
          if (last) begin
            // Odd count: low nibbles undefined, written as zero
            wr_en_o   <= 1'b1;                                  // see RQ11
            wr_addr_o <= {1'b0, idx_q[5:1]};
            wr_data_o <= {dec_lo[3:0], dec_hi[3:0], 8'h00};
          end
        end else begin
          wr_en_o   <= 1'b1;
          wr_addr_o <= {1'b0, idx_q[5:1]};
          wr_data_o <= {hi_q, dec_lo[3:0], dec_hi[3:0]};        // see RQ6
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Completion, output bit and word result

  logic single_op;
  assign single_op = take && !(is_conv && cmd_i.cond && !bad_count);

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      done_o         <= 1'b0;
      out_bit_o      <= 1'b0;
      boundary_err_o <= 1'b0;
      busy_o         <= 1'b0;
      result_word_o  <= hex_ascii_pkg::WORD_RESET;
    end else begin
      done_o         <= single_op || fin_ok || fin_err;
      boundary_err_o <= take && cmd_i.cond && bad_count;        // see RQ5 RQ10
      busy_o         <= launch || (busy_o && !(fin_ok || fin_err));
      if (fin_ok || fin_err) begin
        out_bit_o <= fin_ok;                                    // see RQ1 RQ9
      end else if (single_op) begin
        out_bit_o <= 1'b0;                                      // see RQ17
        if (cmd_i.cond) begin
          unique case (cmd_i.op)
            hex_ascii_pkg::bit_test_op: begin
              out_bit_o <= |(cmd_i.src_word & cmd_i.test_word);  // see RQ12
            end
            hex_ascii_pkg::single_right_shift_op: begin
              result_word_o <= {1'b0, cmd_i.src_word[15:1]};    // see RQ13 RQ18
              out_bit_o     <= cmd_i.src_word[1];               // see RQ14
            end
            hex_ascii_pkg::single_left_shift_op: begin
              result_word_o <= {cmd_i.src_word[14:0], 1'b0};    // see RQ15
              out_bit_o     <= cmd_i.src_word[14];              // see RQ16
            end
            default: out_bit_o <= 1'b0;                         // Refused conversion
          endcase
        end
      end
    end
  end

  // Carry flag: only touched by an executed shift
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      carry_flag_o <= hex_ascii_pkg::CARRY_RESET;
    end else if (take && cmd_i.cond) begin
      if (cmd_i.op == hex_ascii_pkg::single_right_shift_op) begin
        carry_flag_o <= cmd_i.src_word[0];                      // see RQ13
      end else if (cmd_i.op == hex_ascii_pkg::single_left_shift_op) begin
        carry_flag_o <= cmd_i.src_word[15];                     // see RQ15
      end
    end
  end

  // Error flag is sticky; a new error beats a clear in the same cycle
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      error_flag_o <= hex_ascii_pkg::ERROR_RESET;
    end else if (fin_err) begin
      error_flag_o <= 1'b1;                                     // see RQ9
    end else if (err_clr_i) begin
      error_flag_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic [6:0] wr_cnt_q;
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_cnt_q <= 7'h00;
    end else if (launch) begin
      wr_cnt_q <= 7'h00;
    end else if (wr_en_o) begin
      wr_cnt_q <= wr_cnt_q + 7'h01;
    end
  end

  sequence s_take_on(hex_ascii_pkg::op_t o);
    take && cmd_i.cond && cmd_i.op == o;
  endsequence

  chk_test_result: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // see RQ12
    s_take_on(hex_ascii_pkg::bit_test_op) |=> done_o && out_bit_o == $past(|(cmd_i.src_word & cmd_i.test_word)))
    else $error("bit test output wrong");
  chk_right_shift: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // see RQ13 RQ14
    s_take_on(hex_ascii_pkg::single_right_shift_op) |=>
      carry_flag_o == $past(cmd_i.src_word[0]) && out_bit_o == result_word_o[0] && !result_word_o[15])
    else $error("right shift wrong");
  chk_left_shift: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // see RQ15 RQ16
    s_take_on(hex_ascii_pkg::single_left_shift_op) |=>
      carry_flag_o == $past(cmd_i.src_word[15]) && out_bit_o == result_word_o[15] && !result_word_o[0])
    else $error("left shift wrong");
  chk_cond_off: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // see RQ17
    take && !cmd_i.cond |=> done_o && !out_bit_o && $stable(carry_flag_o) && !wr_en_o && !busy_o)
    else $error("operation ran with condition off");
  chk_boundary_err: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // see RQ5 RQ10
    take && cmd_i.cond && is_conv && cmd_i.src_indexed && cmd_i.count > 7'h01 |=>
      boundary_err_o && done_o && !out_bit_o ##1 !busy_o)
    else $error("indexed overrun not refused");
  chk_char_legal: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // see RQ4
    wr_en_o && op_q == hex_ascii_pkg::hex_to_text_op |-> from_ascii(wr_data_o[7:0]) >= 5'h10 &&
      from_ascii(wr_data_o[15:8]) >= 5'h10)
    else $error("illegal character written");
  chk_no_early_write: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // see RQ9
    wr_en_o && op_q == hex_ascii_pkg::text_to_hex_op |-> pass_q || $past(pass_q))
    else $error("write before validation finished");
  chk_bad_char_err: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // see RQ9
    fin_err |=> error_flag_o && done_o && !out_bit_o)
    else $error("bad character not flagged");
  chk_h2t_words: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // see RQ1 RQ4
    done_o && $past(fin_ok) && op_q == hex_ascii_pkg::hex_to_text_op |=> wr_cnt_q == {count_q[5:0], 1'b0})
    else $error("wrong destination word count");
  chk_conv_ends: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // see RQ19
    launch |-> ##[4:400] done_o)
    else $error("conversion did not finish");

endmodule : hex_ascii_convert_bit_shift

`default_nettype wire

// ---- hw/hex_ascii_pkg.sv ----
/*
  Shared types and constants for the hex/text conversion, bit test and
  single-bit shift datapath.
  Assumes a single 100 MHz scan-engine clock and 16-bit words throughout.
*/
package hex_ascii_pkg;

  // Word layout: bit 15 is the MSB, bits 7..0 the low byte
  localparam int unsigned WORD_W   = 16;
  localparam int unsigned BYTE_W   = 8;
  localparam int unsigned NIB_W    = 4;
  localparam int unsigned CNT_W    = 7;
  localparam int unsigned ADDR_W   = 6;

  // Word counts accepted per conversion
  localparam logic [6:0]  H2T_MAX_COUNT = 7'h20;
  localparam logic [6:0]  T2H_MAX_COUNT = 7'h40;
  localparam logic [6:0]  INDEXED_COUNT = 7'h01;

  // Character codes
  localparam logic [7:0]  DIGIT_BASE  = 8'h30;
  localparam logic [7:0]  DIGIT_LAST  = 8'h39;
  localparam logic [7:0]  LETTER_BASE = 8'h41;
  localparam logic [7:0]  LETTER_LAST = 8'h46;
  localparam logic [7:0]  LETTER_OFS  = 8'h0a;

  // Values after reset
  localparam logic        CARRY_RESET = 1'b0;
  localparam logic        ERROR_RESET = 1'b0;
  localparam logic [15:0] WORD_RESET  = 16'h0000;

  typedef logic [WORD_W-1:0] word_t;

  typedef enum logic [2:0] {
    hex_to_text_op,
    text_to_hex_op,
    bit_test_op,
    single_right_shift_op,
    single_left_shift_op
  } op_t;

  // One instruction as issued by the sequencer
  typedef struct packed {
    op_t              op;
    logic             cond;
    logic             src_indexed;
    logic [CNT_W-1:0] count;
    word_t            src_word;
    word_t            test_word;
  } cmd_t;

endpackage : hex_ascii_pkg

// ---- verif/table_mem_model.sv ----
/*
  Table memory behind the datapath: source table read, destination table written.
  Assumes reads are answered in the cycle after rd_en_i is sampled high.
*/
`timescale 1ns/100ps
`default_nettype none
module table_mem_model (
  // Clock
  input  wire logic        clk_sys_i,
  // Read side
  input  wire logic        rd_en_i,
  input  wire logic [5:0]  rd_addr_i,
  output logic      [15:0] rdata_o,
  // Write side
  input  wire logic        wr_en_i,
  input  wire logic [5:0]  wr_addr_i,
  input  wire logic [15:0] wr_data_i
);
  logic [15:0] src [64];
  logic [15:0] dst [64];
  // Data good for one cycle only; it toggles after so a late capture shows
  always @(posedge clk_sys_i) begin
    rdata_o <= rd_en_i ? src[rd_addr_i] : ~rdata_o;
    if (wr_en_i)
      dst[wr_addr_i] <= wr_data_i;
  end
  initial rdata_o = 16'h0000;
endmodule : table_mem_model
`default_nettype wire

// ---- verif/hex_ascii_convert_bit_shift_tb.sv ----
/*
  Self-checking bench for the conversion, bit test and single shift datapath.
  Assumes the table memory model answers reads one cycle after rd_en_o.
*/
`timescale 1ns/100ps
`default_nettype none
module hex_ascii_convert_bit_shift_tb;
  logic                 clk_sys_i = 1'b0;
  logic                 nrst_i    = 1'b0;
  logic                 start_i   = 1'b0;
  hex_ascii_pkg::cmd_t  cmd_i     = '0;
  logic                 err_clr_i = 1'b0;
  logic                 rd_en_o, wr_en_o, busy_o, done_o, out_bit_o;
  logic                 boundary_err_o, carry_flag_o, error_flag_o;
  logic [5:0]           rd_addr_o, wr_addr_o;
  logic [15:0]          mem_rdata_i, wr_data_o;
  hex_ascii_pkg::word_t result_word_o, rw;
  logic                 ob, be, cf, ef, b1;
  int                   fails = 0, checked = 0, seed = 68688, wr_cnt = 0;
  logic [7:0]           bad [6] = '{8'h2f, 8'h3a, 8'h40, 8'h47, 8'h61, 8'hff};

  hex_ascii_convert_bit_shift i_dut (.clk_sys_i, .nrst_i, .start_i, .cmd_i, .err_clr_i, .rd_en_o, .rd_addr_o,
    .mem_rdata_i, .wr_en_o, .wr_addr_o, .wr_data_o, .busy_o, .done_o, .out_bit_o, .boundary_err_o,
    .carry_flag_o, .error_flag_o, .result_word_o);
  table_mem_model i_mem (.clk_sys_i, .rd_en_i(rd_en_o), .rd_addr_i(rd_addr_o), .rdata_o(mem_rdata_i),
    .wr_en_i(wr_en_o), .wr_addr_i(wr_addr_o), .wr_data_i(wr_data_o));

  // 100 MHz clock
  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // Count every destination write, stray ones included
  always @(posedge clk_sys_i) begin
    if (wr_en_o === 1'b1)
      wr_cnt++;
  end
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] asc(logic [3:0] v);
    return (v < 4'ha) ? 8'h30 + 8'(v) : 8'h37 + 8'(v);
  endfunction : asc
  function automatic logic [3:0] nv(logic [7:0] c);
    return (c < 8'h41) ? 4'(c - 8'h30) : 4'(c - 8'h37);
  endfunction : nv
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Source table random (hex or legal text), destination poisoned
  task automatic prep(bit txt);
    for (int i = 0; i < 64; i++) begin
      i_mem.src[i] = txt ? {asc(4'($random(seed))), asc(4'($random(seed)))} : 16'($random(seed));
      i_mem.dst[i] = 16'hbeef;
    end
  endtask : prep
  // One command; results captured in the done cycle, then one cycle to settle
  task automatic run(hex_ascii_pkg::op_t op, logic cnd, logic idx, logic [6:0] n, hex_ascii_pkg::word_t sw, tw);
    int k;
    @(posedge clk_sys_i);
    start_i <= 1'b1;
    cmd_i <= '{op, cnd, idx, n, sw, tw};
    @(posedge clk_sys_i);
    start_i <= 1'b0;
    k = 0;
    do begin
      @(negedge clk_sys_i);
      k++;
      if (k == 1)
        b1 = busy_o;
    end while (done_o !== 1'b1 && k < 1000);
    if (k >= 1000)
      chk("done", 16'h1, 16'h0);
    {ob, be, cf, ef, rw} = {out_bit_o, boundary_err_o, carry_flag_o, error_flag_o, result_word_o};
    @(negedge clk_sys_i);
  endtask : run
  task automatic close_out;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    int n, i, j, w0;
    logic [15:0] w, e;
    logic cf0;
    repeat (3) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    // Hex to text: counts 1, 32, indexed 1, random
    for (j = 0; j < 6; j++) begin
      n = (j != 1) ? ((j % 3 == 0) ? 1 : 1 + {$random(seed)} % 32) : 32;
      prep(0);
      w0 = wr_cnt;
      run(hex_ascii_pkg::hex_to_text_op, 1'b1, j == 3, n[6:0], 16'h0, 16'h0);
      chk("h2t out", 16'h1, {15'h0, ob});
      chk("h2t bnd", 16'h0, {15'h0, be});
      chk("h2t busy", 16'h1, {15'h0, b1});
      chk("h2t writes", 16'(2 * n), 16'(wr_cnt - w0));
      for (i = 0; i < n; i++) begin
        w = i_mem.src[i];
        chk("h2t even", {asc(w[11:8]), asc(w[15:12])}, i_mem.dst[2*i]);
        chk("h2t odd", {asc(w[3:0]), asc(w[7:4])}, i_mem.dst[2*i+1]);
      end
    end
    $display("test hex to text done");
    // Text to hex: counts 64, indexed 1, random odd and even
    for (j = 0; j < 6; j++) begin
      n = (j == 0) ? 64 : (j == 1) ? 1 : 1 + {$random(seed)} % 64;
      prep(1);
      w0 = wr_cnt;
      run(hex_ascii_pkg::text_to_hex_op, 1'b1, j == 1, n[6:0], 16'h0, 16'h0);
      chk("t2h out", 16'h1, {15'h0, ob});
      chk("t2h err", 16'h0, {15'h0, ef});
      chk("t2h busy", 16'h1, {15'h0, b1});
      chk("t2h writes", 16'((n + 1) / 2), 16'(wr_cnt - w0));
      for (i = 0; i < (n + 1) / 2; i++) begin
        e = {nv(i_mem.src[2*i][7:0]), nv(i_mem.src[2*i][15:8]), nv(i_mem.src[2*i+1][7:0]),
             nv(i_mem.src[2*i+1][15:8])};
        if (2 * i + 1 == n)
          e[7:0] = 8'h00;
        chk("t2h word", e, i_mem.dst[i]);
      end
    end
    $display("test text to hex done");
    // Illegal character: nothing written, flag sticks through a good run
    for (j = 0; j < 6; j++) begin
      prep(1);
      n = {$random(seed)} % 8;
      if (j % 2 == 1)
        i_mem.src[n][15:8] = bad[j];
      else
        i_mem.src[n][7:0] = bad[j];
      w0 = wr_cnt;
      run(hex_ascii_pkg::text_to_hex_op, 1'b1, 1'b0, 7'h08, 16'h0, 16'h0);
      chk("bad out", 16'h0, {15'h0, ob});
      chk("bad err", 16'h1, {15'h0, ef});
      chk("bad writes", 16'h0, 16'(wr_cnt - w0));
      prep(1);
      run(hex_ascii_pkg::text_to_hex_op, 1'b1, 1'b0, 7'h02, 16'h0, 16'h0);
      chk("kept err", 16'h1, {15'h0, ef});
      @(posedge clk_sys_i);
      err_clr_i <= 1'b1;
      @(posedge clk_sys_i);
      err_clr_i <= 1'b0;
      @(negedge clk_sys_i);
      chk("err clear", 16'h0, {15'h0, error_flag_o});
    end
    $display("test bad text done");
    // Refused counts: zero, above range, indexed with count 2
    for (j = 0; j < 6; j++) begin
      n = (j % 3 == 0) ? 0 : (j % 3 == 2) ? 2 : (j < 3) ? 33 : 65;
      w0 = wr_cnt;
      run(j < 3 ? hex_ascii_pkg::hex_to_text_op : hex_ascii_pkg::text_to_hex_op, 1'b1, j % 3 == 2, n[6:0],
          16'h0, 16'h0);
      chk("ref bnd", 16'h1, {15'h0, be});
      chk("ref out", 16'h0, {15'h0, ob});
      chk("ref busy", 16'h0, {15'h0, b1});
      chk("ref writes", 16'h0, 16'(wr_cnt - w0));
    end
    $display("test refused counts done");
    // Bit test, zero and all-ones masks first
    for (j = 0; j < 10; j++) begin
      w = 16'($random(seed));
      e = (j == 0) ? 16'h0000 : (j == 1) ? 16'hffff : 16'($random(seed));
      run(hex_ascii_pkg::bit_test_op, 1'b1, 1'b0, 7'h00, w, e);
      chk("test out", {15'h0, |(w & e)}, {15'h0, ob});
      chk("test busy", 16'h0, {15'h0, b1});
    end
    $display("test bit test done");
    // Shifts in pairs: fresh word, then its own result again
    for (j = 0; j < 16; j++) begin
      w = j[0] ? rw : (j < 4) ? 16'h8001 : 16'($random(seed));
      run(j[1] ? hex_ascii_pkg::single_left_shift_op : hex_ascii_pkg::single_right_shift_op, 1'b1, 1'b0,
          7'h00, w, 16'h0);
      e = j[1] ? {w[14:0], 1'b0} : {1'b0, w[15:1]};
      chk("shift word", e, rw);
      chk("shift carry", {15'h0, j[1] ? w[15] : w[0]}, {15'h0, cf});
      chk("shift out", {15'h0, j[1] ? e[15] : e[0]}, {15'h0, ob});
    end
    $display("test shifts done");
    // Condition off for every operation
    for (j = 0; j < 5; j++) begin
      prep(1);
      cf0 = carry_flag_o;
      w = result_word_o;
      w0 = wr_cnt;
      run(hex_ascii_pkg::op_t'(j), 1'b0, 1'b0, 7'h01, 16'hffff, 16'hffff);
      chk("off out", 16'h0, {15'h0, ob});
      chk("off carry", {15'h0, cf0}, {15'h0, cf});
      chk("off word", w, rw);
      chk("off writes", 16'h0, 16'(wr_cnt - w0));
    end
    $display("test condition off done");
    close_out();
  end
  // Watchdog well beyond the expected run time
  initial begin
    #300us;
    chk("watchdog", 16'h1, 16'h0);
    close_out();
  end
endmodule : hex_ascii_convert_bit_shift_tb
`default_nettype wire
